// [rtl/tx_desc_pkg.sv]
// Package: constants and types of the transmit descriptor status block
package tx_desc_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_LIST      = 8'h04;
    localparam logic [7:0] REG_DEMAND    = 8'h08;
    localparam logic [7:0] REG_CUR_DESC  = 8'h0C;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h14;
    localparam logic [7:0] REG_LAST_STAT = 8'h18;
    // Control register fields
    localparam int CTRL_NO_DEFER_LIMIT = 0;
    localparam int CTRL_HALF_DUPLEX    = 1;
    localparam int CTRL_SPEED_100      = 2;
    localparam int CTRL_W              = 3;
    localparam logic [31:0] LIST_RESET = 32'hFFFF_FFFC;
    // Descriptor word offsets in bytes
    localparam logic [31:0] DESC_BUF_OFS  = 32'h0000_0004;
    localparam logic [31:0] DESC_CNT_OFS  = 32'h0000_0008;
    localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_000C;
    // Descriptor status bits
    localparam int STAT_NO_CARRIER = 21;
    localparam int STAT_EXCESS_DEFER_FLAG      = 20;
    localparam int STAT_COMPLETE   = 19;
    localparam int STAT_DEFERRED   = 17;
    localparam int STAT_IRQ_CAUSE  = 16;
    localparam int COUNT_W         = 16;
    // Interrupt bits
    localparam int IRQ_W         = 3;
    localparam int IRQ_DONE      = 0;
    localparam int IRQ_EXCESS_DEFER_FLAG     = 1;
    localparam int IRQ_NOCARRIER = 2;
    // Deferral limits
    localparam int CLK_PERIOD_NS    = 50;
    localparam int DEFER_100_NS     = 327680;
    localparam int DEFER_10_NS      = 3276800;
    localparam int DEFER_100_CYCLES = (DEFER_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEFER_10_CYCLES  = (DEFER_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEFER_CNT_W      = 17;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_BUF, ST_RD_CNT, ST_RD_NEXT, ST_SEND, ST_WR_STAT
    } tx_state_t;
endpackage

// [rtl/tx_aux_if.sv]
// Interface: links the core with its deferral timer and interrupt bank
`timescale 1ns/100ps
interface tx_aux_if;
    logic                            defer_run;
    logic                            defer_clear;
    logic                            speed_100;
    logic                            defer_exceeded;
    logic [tx_desc_pkg::IRQ_W-1:0]   irq_set;
    logic [tx_desc_pkg::IRQ_W-1:0]   irq_mask;
    logic                            irq_clear;
    logic [tx_desc_pkg::IRQ_W-1:0]   irq_status;
    logic                            irq_line;
    modport core_mp (output defer_run, defer_clear, speed_100, irq_set, irq_mask, irq_clear,
                     input defer_exceeded, irq_status, irq_line);
    modport defer_mp (input defer_run, defer_clear, speed_100, output defer_exceeded);
    modport irq_mp (input irq_set, irq_mask, irq_clear, output irq_status, irq_line);
endinterface

// [rtl/defer_timer.sv]
// Deferral timer: flags a frame that waited past the speed's limit
`timescale 1ns/100ps
module defer_timer #(
    parameter logic [tx_desc_pkg::DEFER_CNT_W-1:0] LIMIT_100 = 17'(tx_desc_pkg::DEFER_100_CYCLES),
    parameter logic [tx_desc_pkg::DEFER_CNT_W-1:0] LIMIT_10  = 17'(tx_desc_pkg::DEFER_10_CYCLES)
) (
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // Core side
    tx_aux_if.defer_mp    aux
);
    typedef struct packed {
        logic [tx_desc_pkg::DEFER_CNT_W-1:0] count;
        logic                                exceeded;
    } defer_state_t;
    defer_state_t                        st_reg;
    defer_state_t                        st_next;
    logic [tx_desc_pkg::DEFER_CNT_W-1:0] lim;

    // Count run cycles; the flag sticks until the next frame
    always_comb begin
        lim = aux.speed_100 ? LIMIT_100 : LIMIT_10;
        st_next = st_reg;
        if (aux.defer_clear) begin
            st_next = '0;
        end else if (aux.defer_run && !st_reg.exceeded) begin
            if (st_reg.count >= lim) begin
                st_next.exceeded = 1'b1;
            end else begin
                st_next.count = st_reg.count + 17'h0_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign aux.defer_exceeded = st_reg.exceeded;

    a_exceed_at_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_reg.exceeded) |-> $past(st_reg.count) == $past(lim))
        else $error("deferral flag not raised at the limit");
    a_exceed_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_reg.exceeded) |-> $past(aux.defer_run))
        else $error("deferral flag raised while check disabled");
endmodule // defer_timer

// [rtl/irq_bank.sv]
// Interrupt bank: sticky status bits, read-clear, masked level output
`timescale 1ns/100ps
module irq_bank (
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // Core side
    tx_aux_if.irq_mp      aux
);
    typedef struct packed {
        logic [tx_desc_pkg::IRQ_W-1:0] status;
    } irq_state_t;
    irq_state_t st_reg;
    irq_state_t st_next;

    // A set in the clearing cycle wins, so no event is lost
    always_comb begin
        st_next = st_reg;
        if (aux.irq_clear) begin
            st_next.status = '0;
        end
        st_next.status = st_next.status | aux.irq_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign aux.irq_status = st_reg.status;
    assign aux.irq_line   = |(st_reg.status & aux.irq_mask);
endmodule // irq_bank

// [rtl/tx_desc_status.sv]
// Transmit descriptor walker with status write-back and register slave
//
// Notes on behaviour
// - Flag excessive deferral in bit 20 past 0.32768 ms (100M) or 3.2768 ms (10M).
// - Deferral check only when no-defer-limit is clear and half duplex.
// - Bit 19 set when the frame completed correctly, else zero.
// - Bit 17 set when transmission deferred once, half duplex only.
// - Bit 16 set when the frame raised an interrupt condition; here only a condition enabled in irq_mask sets it.
// - Low 16 bits of the count word give the bytes to send.
// - Fourth descriptor word points to the next descriptor; walk follows it.
// - Low two pointer bits are ignored; descriptors sit on word boundaries.
// - Bit 21 set when carrier sense never showed during a half-duplex frame.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module tx_desc_status #(
    parameter logic [16:0] DEFER_LIMIT_100 = 17'(tx_desc_pkg::DEFER_100_CYCLES),
    parameter logic [16:0] DEFER_LIMIT_10  = 17'(tx_desc_pkg::DEFER_10_CYCLES)
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Descriptor memory master
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [31:0] mem_adr_o,
    output logic      [31:0] mem_dat_o,
    input  wire logic [31:0] mem_dat_i,
    input  wire logic        mem_ack_i,
    // MAC transmit path
    output logic             tx_start_o,
    output logic      [31:0] tx_buf_adr_o,
    output logic      [15:0] tx_frame_byte_count_o,
    input  wire logic        tx_done_i,
    input  wire logic        tx_ok_i,
    input  wire logic        tx_active_i,
    input  wire logic        tx_defer_i,
    input  wire logic        crs_i,
    // Interrupt
    output logic             irq_o
);
    typedef struct packed {
        tx_desc_pkg::tx_state_t           fsm;
        logic [tx_desc_pkg::CTRL_W-1:0]   ctrl;
        logic [31:0]                      list_start;
        logic [31:0]                      cur_desc;
        logic [31:0]                      buf_adr;
        logic [15:0]                      byte_count;
        logic [31:0]                      next_ptr;
        logic [31:0]                      last_stat;
        logic [tx_desc_pkg::IRQ_W-1:0]    irq_mask;
        logic                             pending;
        logic                             deferred;
        logic                             crs_seen;
        logic                             mem_req;
        logic                             mem_we;
        logic [31:0]                      mem_adr;
        logic [31:0]                      mem_wdat;
        logic                             tx_start;
        logic                             ack;
        logic [31:0]                      rdat;
    } core_state_t;

    core_state_t                      st_reg;
    core_state_t                      st_next;
    logic                             bus_req;
    logic                             bus_wr;
    logic                             half_dup;
    logic                             no_carrier;
    logic [tx_desc_pkg::IRQ_W-1:0]    events;
    logic                             irq_cause;
    logic [31:0]                      stat_word;

    tx_aux_if aux ();

    defer_timer #(
        .LIMIT_100 (DEFER_LIMIT_100),
        .LIMIT_10  (DEFER_LIMIT_10)
    ) u_defer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .aux   (aux.defer_mp)
    );

    irq_bank u_irq (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .aux   (aux.irq_mp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame status terms
    always_comb begin
        half_dup   = st_reg.ctrl[tx_desc_pkg::CTRL_HALF_DUPLEX];
        no_carrier = half_dup && !st_reg.crs_seen;
        events     = '0;
        events[tx_desc_pkg::IRQ_DONE]      = tx_done_i && st_reg.fsm == tx_desc_pkg::ST_SEND;
        events[tx_desc_pkg::IRQ_EXCESS_DEFER_FLAG]     = events[tx_desc_pkg::IRQ_DONE]
                                             && aux.defer_exceeded;
        events[tx_desc_pkg::IRQ_NOCARRIER] = events[tx_desc_pkg::IRQ_DONE] && no_carrier;
        irq_cause  = |(events & st_reg.irq_mask);
        stat_word  = 32'h0000_0000;
        stat_word[tx_desc_pkg::COUNT_W-1:0]    = st_reg.byte_count;
        stat_word[tx_desc_pkg::STAT_NO_CARRIER] = no_carrier;
        stat_word[tx_desc_pkg::STAT_EXCESS_DEFER_FLAG]     = aux.defer_exceeded;
        stat_word[tx_desc_pkg::STAT_COMPLETE]  = tx_ok_i;
        stat_word[tx_desc_pkg::STAT_DEFERRED]  = half_dup && (st_reg.deferred || tx_defer_i);
        stat_word[tx_desc_pkg::STAT_IRQ_CAUSE] = irq_cause;
    end

    // Deferral check runs only while waiting to send, half duplex, limit on
    assign aux.defer_run   = st_reg.fsm == tx_desc_pkg::ST_SEND && tx_defer_i && !tx_active_i
                             && half_dup && !st_reg.ctrl[tx_desc_pkg::CTRL_NO_DEFER_LIMIT];
    assign aux.defer_clear = st_reg.tx_start;
    assign aux.speed_100   = st_reg.ctrl[tx_desc_pkg::CTRL_SPEED_100];
    assign aux.irq_set     = events;
    assign aux.irq_mask    = st_reg.irq_mask;
    assign aux.irq_clear   = bus_req && !wb_we_i && wb_adr_i == tx_desc_pkg::REG_IRQ_STAT;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and walker; ack comes one cycle after the strobe
    always_comb begin
        st_next  = st_reg;
        bus_req  = wb_cyc_i && wb_stb_i && !st_reg.ack;
        bus_wr   = bus_req && wb_we_i && wb_sel_i == 4'hF;
        st_next.ack      = bus_req;
        st_next.tx_start = 1'b0;
        // Register reads; unmapped offsets read zero
        st_next.rdat = 32'h0000_0000;
        case (wb_adr_i)
            tx_desc_pkg::REG_CTRL:      st_next.rdat = {29'h0, st_reg.ctrl};
            tx_desc_pkg::REG_LIST:      st_next.rdat = st_reg.list_start;
            tx_desc_pkg::REG_CUR_DESC:  st_next.rdat = st_reg.cur_desc;
            tx_desc_pkg::REG_IRQ_STAT:  st_next.rdat = {29'h0, aux.irq_status};
            tx_desc_pkg::REG_IRQ_MASK:  st_next.rdat = {29'h0, st_reg.irq_mask};
            tx_desc_pkg::REG_LAST_STAT: st_next.rdat = st_reg.last_stat;
            default:                    st_next.rdat = 32'h0000_0000;
        endcase
        // Register writes need all four lanes
        if (bus_wr) begin
            case (wb_adr_i)
                tx_desc_pkg::REG_CTRL: begin
                    st_next.ctrl = wb_dat_i[tx_desc_pkg::CTRL_W-1:0];
                end
                tx_desc_pkg::REG_LIST: begin
                    st_next.list_start = {wb_dat_i[31:2], 2'b00};
                    if (st_reg.fsm == tx_desc_pkg::ST_IDLE) begin
                        st_next.cur_desc = {wb_dat_i[31:2], 2'b00};
                    end
                end
                tx_desc_pkg::REG_DEMAND: begin
                    st_next.pending = 1'b1;
                end
                tx_desc_pkg::REG_IRQ_MASK: begin
                    st_next.irq_mask = wb_dat_i[tx_desc_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Memory request drops on its ack
        if (mem_ack_i) begin
            st_next.mem_req = 1'b0;
            st_next.mem_we  = 1'b0;
        end
        case (st_reg.fsm)
            tx_desc_pkg::ST_IDLE: begin
                if (st_reg.pending) begin
                    st_next.pending = 1'b0;
                    st_next.mem_req = 1'b1;
                    st_next.mem_adr = st_reg.cur_desc + tx_desc_pkg::DESC_BUF_OFS;
                    st_next.fsm     = tx_desc_pkg::ST_RD_BUF;
                end
            end
            tx_desc_pkg::ST_RD_BUF: begin
                if (mem_ack_i) begin
                    st_next.buf_adr = mem_dat_i;
                    st_next.mem_req = 1'b1;
                    st_next.mem_adr = st_reg.cur_desc + tx_desc_pkg::DESC_CNT_OFS;
                    st_next.fsm     = tx_desc_pkg::ST_RD_CNT;
                end
            end
            tx_desc_pkg::ST_RD_CNT: begin
                if (mem_ack_i) begin
                    st_next.byte_count = mem_dat_i[tx_desc_pkg::COUNT_W-1:0];
                    st_next.mem_req    = 1'b1;
                    st_next.mem_adr    = st_reg.cur_desc + tx_desc_pkg::DESC_NEXT_OFS;
                    st_next.fsm        = tx_desc_pkg::ST_RD_NEXT;
                end
            end
            tx_desc_pkg::ST_RD_NEXT: begin
                if (mem_ack_i) begin
                    st_next.next_ptr = {mem_dat_i[31:2], 2'b00};
                    // A zero byte count ends the walk without sending
                    if (st_reg.byte_count == 16'h0000) begin
                        st_next.fsm = tx_desc_pkg::ST_IDLE;
                    end else begin
                        st_next.tx_start = 1'b1;
                        st_next.deferred = 1'b0;
                        st_next.crs_seen = 1'b0;
                        st_next.fsm      = tx_desc_pkg::ST_SEND;
                    end
                end
            end
            tx_desc_pkg::ST_SEND: begin
                st_next.deferred = st_reg.deferred || tx_defer_i;
                st_next.crs_seen = st_reg.crs_seen || (crs_i && tx_active_i);
                // Status goes back only once the MAC reports the end
                if (tx_done_i) begin
                    st_next.last_stat = stat_word;
                    st_next.mem_req   = 1'b1;
                    st_next.mem_we    = 1'b1;
                    st_next.mem_adr   = st_reg.cur_desc + tx_desc_pkg::DESC_CNT_OFS;
                    st_next.mem_wdat  = stat_word;
                    st_next.fsm       = tx_desc_pkg::ST_WR_STAT;
                end
            end
            tx_desc_pkg::ST_WR_STAT: begin
                if (mem_ack_i) begin
                    st_next.cur_desc = st_reg.next_ptr;
                    st_next.mem_req  = 1'b1;
                    st_next.mem_adr  = st_reg.next_ptr + tx_desc_pkg::DESC_BUF_OFS;
                    st_next.fsm      = tx_desc_pkg::ST_RD_BUF;
                end
            end
            default: begin
                st_next.fsm = tx_desc_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg            <= '0;
            st_reg.fsm        <= tx_desc_pkg::ST_IDLE;
            st_reg.list_start <= tx_desc_pkg::LIST_RESET;
            st_reg.cur_desc   <= tx_desc_pkg::LIST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o              = st_reg.ack;
    assign wb_dat_o              = st_reg.rdat;
    assign mem_req_o             = st_reg.mem_req;
    assign mem_we_o              = st_reg.mem_we;
    assign mem_adr_o             = st_reg.mem_adr;
    assign mem_dat_o             = st_reg.mem_wdat;
    assign tx_start_o            = st_reg.tx_start;
    assign tx_buf_adr_o          = st_reg.buf_adr;
    assign tx_frame_byte_count_o = st_reg.byte_count;
    assign irq_o                 = aux.irq_line;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_count_from_desc: assert property (
        st_reg.fsm == tx_desc_pkg::ST_RD_CNT && mem_ack_i
        |=> tx_frame_byte_count_o == $past(mem_dat_i[tx_desc_pkg::COUNT_W-1:0]))
        else $error("byte count not taken from descriptor");
    a_next_ptr_align: assert property (
        st_reg.fsm == tx_desc_pkg::ST_RD_NEXT && mem_ack_i
        |=> st_reg.next_ptr == {$past(mem_dat_i[31:2]), 2'b00})
        else $error("next pointer not word aligned");
    a_walk_follows: assert property (
        st_reg.fsm == tx_desc_pkg::ST_WR_STAT && mem_ack_i
        |=> mem_adr_o == $past(st_reg.next_ptr) + tx_desc_pkg::DESC_BUF_OFS)
        else $error("walk did not follow the next pointer");
    a_wb_after_done: assert property (
        $rose(mem_req_o && mem_we_o) |-> $past(tx_done_i)
        && mem_adr_o == st_reg.cur_desc + tx_desc_pkg::DESC_CNT_OFS)
        else $error("status written before frame end");
    a_complete_bit: assert property (
        $rose(mem_req_o && mem_we_o) |-> mem_dat_o[tx_desc_pkg::STAT_COMPLETE] == $past(tx_ok_i))
        else $error("completion bit wrong");
    a_defer_half_only: assert property (
        $rose(mem_req_o && mem_we_o) |-> !mem_dat_o[tx_desc_pkg::STAT_DEFERRED] || half_dup)
        else $error("deferred bit set in full duplex");
    a_no_carrier_bit: assert property (
        $rose(mem_req_o && mem_we_o)
        |-> mem_dat_o[tx_desc_pkg::STAT_NO_CARRIER] == (half_dup && !st_reg.crs_seen))
        else $error("no carrier bit wrong");
    a_irq_cause_bit: assert property (
        $rose(mem_req_o && mem_we_o)
        |-> mem_dat_o[tx_desc_pkg::STAT_IRQ_CAUSE] == $past(irq_cause))
        else $error("interrupt cause bit wrong");
    a_excess_defer_flag_bit: assert property (
        $rose(mem_req_o && mem_we_o)
        |-> mem_dat_o[tx_desc_pkg::STAT_EXCESS_DEFER_FLAG] == aux.defer_exceeded)
        else $error("excessive deferral bit wrong");
endmodule // tx_desc_status

// [dv/desc_mem_model.sv]
// Descriptor memory model: word store that answers after a set delay
`timescale 1ns/100ps
module desc_mem_model (
    // Clock
    input  wire logic        clk_i,
    // Request side
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] wdat_i,
    input  wire logic [3:0]  delay_i,
    // Answer side
    output logic             ack_o,
    output logic      [31:0] rdat_o
);
    logic [31:0] mem [0:63];
    logic [3:0]  wait_cnt = 4'h0;
    logic        hit;

    ////////////////////////////////////////////////////////////////
    // Quiet bus at time zero
    initial begin
        ack_o = 1'b0;
        rdat_o = 32'h0;
    end

    // Answer once delay_i cycles have passed
    assign hit = req_i && !ack_o && (wait_cnt >= delay_i);

    // Outside the ack cycle the data toggles, so a stale word never passes as fresh
    always @(posedge clk_i) begin
        ack_o <= hit;
        rdat_o <= hit ? mem[adr_i[7:2]] : ~rdat_o;
        wait_cnt <= (req_i && !hit && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
        if (hit && we_i) begin
            mem[adr_i[7:2]] <= wdat_i;
        end
    end
endmodule // desc_mem_model

// [dv/tb_eth_tx_descriptor_status.sv]
// Testbench: descriptor walks checked against a reference status model
`timescale 1ns/100ps
module tb_eth_tx_descriptor_status;
    localparam int L100 = 20;
    localparam int L10  = 40;
    typedef struct {int d; bit ok; bit crs; logic [15:0] cnt; logic [31:0] ba;} frame_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, crs = 1'b0;
    logic        tx_done = 1'b0, tx_ok = 1'b0, tx_act = 1'b0, tx_defer = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, mem_dly = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, m_adr, m_wd, m_rd, buf_adr;
    logic [15:0] byte_cnt;
    logic        ack, m_req, m_we, m_ack, tx_start, irq;
    int          n_errors = 0, tests_run = 0, n_end = 0, n_wr = 0;
    frame_t      q_frame[$];
    logic [31:0] q_stat[$], q_adr[$];

    tx_desc_status #(.DEFER_LIMIT_100(17'(L100)), .DEFER_LIMIT_10(17'(L10))) i_tx_desc_status (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mem_req_o(m_req), .mem_we_o(m_we), .mem_adr_o(m_adr), .mem_dat_o(m_wd),
        .mem_dat_i(m_rd), .mem_ack_i(m_ack), .tx_start_o(tx_start), .tx_buf_adr_o(buf_adr),
        .tx_frame_byte_count_o(byte_cnt), .tx_done_i(tx_done), .tx_ok_i(tx_ok),
        .tx_active_i(tx_act), .tx_defer_i(tx_defer), .crs_i(crs), .irq_o(irq));
    desc_mem_model i_mem (.clk_i(clk_i), .req_i(m_req), .we_i(m_we), .adr_i(m_adr),
        .wdat_i(m_wd), .delay_i(mem_dly), .ack_o(m_ack), .rdat_o(m_rd));

    ////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Classic cycle; cyc doubles as stb, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // MAC stand-in: defer, send with or without carrier, end the frame
    initial begin : mac
        frame_t f;
        forever begin
            @(posedge clk_i);
            if (tx_start === 1'b1 && q_frame.size() != 0) begin
                f = q_frame.pop_front();
                chk(32'(byte_cnt), 32'(f.cnt));
                chk(buf_adr, f.ba);
                if (f.d != 0) begin
                    tx_defer <= 1'b1;
                    repeat (f.d) @(posedge clk_i);
                end
                tx_defer <= 1'b0;
                tx_act <= 1'b1;
                crs <= f.crs;
                repeat (4) @(posedge clk_i);
                tx_act <= 1'b0;
                crs <= 1'b0;
                tx_done <= 1'b1;
                tx_ok <= f.ok;
                @(posedge clk_i);
                tx_done <= 1'b0;
                n_end++;
            end else if (tx_start === 1'b1) begin
                chk(32'h1, 32'h0);
            end
        end
    end

    // Write-back watcher; a write before the frame ends shows as a count gap
    always @(posedge clk_i) begin
        if (m_req === 1'b1 && m_we === 1'b1 && m_ack === 1'b1) begin
            n_wr++;
            chk(32'(n_end), 32'(n_wr));
            if (q_stat.size() == 0) begin
                chk(m_adr, 32'hFFFF_FFFF);
            end else begin
                chk(m_adr, q_adr.pop_front());
                chk(m_wd, q_stat.pop_front());
            end
        end
    end

    // Hang guard, far beyond the few thousand cycles of the walks
    initial begin : watchdog
        #1000000;
        n_errors++;
        end_sim();
    end

    // Main sequence: every control mode, deferral at both sides of the limit
    initial begin : main_seq
        logic [31:0] r, base, ctrl, mask, st, xirq;
        frame_t f;
        int lim, n, idx;
        bit hd, exd, nc;
        void'($urandom(9637));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'hF, tx_desc_pkg::REG_LIST, 32'h0, r);
        chk(r, tx_desc_pkg::LIST_RESET);
        wb(1'b0, 4'hF, 8'hFC, 32'h0, r);
        chk(r, 32'h0);
        wb(1'b1, 4'h3, tx_desc_pkg::REG_IRQ_MASK, 32'h7, r);
        wb(1'b0, 4'hF, tx_desc_pkg::REG_IRQ_MASK, 32'h0, r);
        chk(r, 32'h0);
        for (int k = 0; k < 8; k++) begin
            n = 0;
            while (n < 6) begin
                @(posedge clk_i);
                n = (m_req === 1'b1) ? 0 : n + 1;
            end
            ctrl = 32'(k);
            hd = ctrl[tx_desc_pkg::CTRL_HALF_DUPLEX];
            lim = ctrl[tx_desc_pkg::CTRL_SPEED_100] ? L100 : L10;
            mask = 32'($urandom_range(0, 7));
            mem_dly <= 4'(k % 3);
            base = 32'(k % 4) * 32'h40;
            xirq = 32'h0;
            for (int j = 0; j < 4; j++) begin
                f.d = (j == 0) ? 0 : lim - 1 + j;
                f.ok = 1'($urandom_range(0, 1));
                f.crs = 1'($urandom_range(0, 1));
                f.cnt = (j == 3) ? 16'h0 : 16'($urandom_range(1, 65535));
                f.ba = $urandom;
                idx = int'(base[7:2]) + j * 4;
                i_mem.mem[idx + 1] = f.ba;
                i_mem.mem[idx + 2] = {16'h0, f.cnt};
                i_mem.mem[idx + 3] = base + 32'(j * 17 + 16);
                if (j < 3) begin
                    // Waiting exactly the limit is not yet excessive
                    exd = !ctrl[tx_desc_pkg::CTRL_NO_DEFER_LIMIT] && hd && f.d > lim;
                    nc = hd && !f.crs;
                    st = {10'h0, nc, exd, f.ok, 1'b0, hd && f.d > 0,
                          mask[0] | exd & mask[1] | nc & mask[2], f.cnt};
                    xirq |= {29'h0, nc, exd, 1'b1};
                    q_frame.push_back(f);
                    q_stat.push_back(st);
                    q_adr.push_back(base + 32'(j * 16 + 8));
                end
            end
            wb(1'b1, 4'hF, tx_desc_pkg::REG_CTRL, ctrl, r);
            wb(1'b1, 4'hF, tx_desc_pkg::REG_IRQ_MASK, mask, r);
            wb(1'b1, 4'hF, tx_desc_pkg::REG_LIST, base | 32'h3, r);
            wb(1'b1, 4'hF, tx_desc_pkg::REG_DEMAND, 32'h1, r);
            while (q_stat.size() != 0) @(posedge clk_i);
            wb(1'b0, 4'hF, tx_desc_pkg::REG_LAST_STAT, 32'h0, r);
            chk(r, st);
            wb(1'b0, 4'hF, tx_desc_pkg::REG_CUR_DESC, 32'h0, r);
            chk(r, base + 32'h30);
            chk(32'(irq), 32'(|(xirq & mask)));
            wb(1'b0, 4'hF, tx_desc_pkg::REG_IRQ_STAT, 32'h0, r);
            chk(r, xirq);
            wb(1'b0, 4'hF, tx_desc_pkg::REG_CTRL, 32'h0, r);
            chk(r, ctrl);
            chk(32'(irq), 32'h0);
        end
        end_sim();
    end
endmodule // tb_eth_tx_descriptor_status
